// ---- pkg/bbmc_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 200 MHz system clock, 8-bit register port
// Notes: Definitions only
`ifndef BBMC_CONSTS_SVH
`define BBMC_CONSTS_SVH
`define BBMC_ADDR_TARGET_LOW 8'h04
`define BBMC_ADDR_TARGET_HIGH 8'h05
`define BBMC_ADDR_CONTROL 8'h01
`define BBMC_ADDR_STATUS 8'h02
`define BBMC_RST_TARGET_LOW 8'h3C
`define BBMC_RST_TARGET_HIGH 8'h3C
`define BBMC_RST_CONTROL 8'h00
`define BBMC_CTL_SLEW_LO 0
`define BBMC_CTL_RAMP 2
`define BBMC_CTL_FORCED_PWM_BIT 3
`define BBMC_CTL_USONIC 4
`define BBMC_CODE_MSB 6
`define BBMC_CLK_MHZ 200
`define BBMC_ACCESS_DELAY_US 100
`define BBMC_ACCESS_DELAY_CYC (`BBMC_ACCESS_DELAY_US * `BBMC_CLK_MHZ)
`define BBMC_USONIC_KHZ 30
`define BBMC_USONIC_CYC ((`BBMC_CLK_MHZ * 1000) / `BBMC_USONIC_KHZ)
`define BBMC_BASE_MV 1800
`define BBMC_STEP_MV 25
`define BBMC_MAX_ON_CYC 16'd91
`endif

// ---- pkg/bbmc_pkg.sv ----
// Purpose: Types for the buck-boost mode control block
// Assumes: Constants come from bbmc_consts.svh
// Notes: Types only
package bbmc_pkg;
	typedef enum logic [1:0] {BBMC_BUCK, BBMC_BOOST, BBMC_BUCKBOOST} bbmc_phase_e;
	typedef enum logic [2:0] {BBMC_OFF, BBMC_IDLE, BBMC_ON, BBMC_FREE,
		BBMC_OFFT, BBMC_SLEEP} bbmc_state_e;
	// Four power switches: input high/low, output low/high
	typedef struct packed {
		logic input_high_switch;
		logic input_low_switch;
		logic output_low_switch;
		logic output_high_switch;
	} bbmc_switch_s;
	// Analog comparator results
	typedef struct packed {
		logic output_below_ref;
		logic peak_current;
		logic zero_current;
		logic vout_in_range;
		logic continuous;
		logic no_load;
	} bbmc_sense_s;
endpackage

// ---- logic/bbmc_core.sv ----
// Purpose: Switch sequencing, enable, targets and scaling for buck-boost
// Assumes: Comparator and pin inputs are asynchronous; simple register port
// Notes: Analog phase selection arrives as inputs from comparators
`timescale 1ns/1ps
`include "bbmc_consts.svh"
`default_nettype none
module bbmc_core (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Pins
	input wire logic enable_pin_i,
	input wire logic shutdown_pin_i,
	input wire logic uvlo_ok_i,
	input wire logic target_select_pin_i,
	// Analog sense
	input wire bbmc_pkg::bbmc_sense_s sense_i,
	input wire bbmc_pkg::bbmc_phase_e phase_i,
	input wire logic [15:0] on_time_cyc_i,
	input wire logic [15:0] off_time_cyc_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_ack_o,
	// Converter outputs
	output bbmc_pkg::bbmc_switch_s switch_o,
	output logic power_not_good_flag_o,
	output logic [15:0] target_mv_o,
	output logic [15:0] reference_mv_o,
	output logic deep_sleep_state_o,
	output logic pwm_mode_o
);
	localparam int ACC_CYC = `BBMC_ACCESS_DELAY_CYC;
	localparam int US_CYC = `BBMC_USONIC_CYC;

	// Two-flop synchronisers for pins and comparators
	// Phase and one-shot lengths are levels from the analog side, not synced
	logic [9:0] sync1, sync2;
	always_ff @(posedge clk_sys_i) begin
		sync1 <= {enable_pin_i, shutdown_pin_i, uvlo_ok_i, target_select_pin_i, sense_i};
		sync2 <= sync1;
	end
	logic en_s, shdn_s, uvlo_s, sel_s;
	bbmc_pkg::bbmc_sense_s sn;
	assign {en_s, shdn_s, uvlo_s, sel_s} = sync2[9:6];
	assign sn = sync2[5:0];

	// Shutdown acts as a register reset too
	logic rst_all;
	assign rst_all = !nrst_i || shdn_s;
	logic run;
	assign run = en_s && uvlo_s && !shdn_s;

	// Access delay counter after enable rises
	logic en_d;
	logic [15:0] acc_cnt;
	logic acc_ok;
	always_ff @(posedge clk_sys_i) begin
		if (rst_all) begin
			en_d <= 1'b0;
			acc_cnt <= 16'h0000;
		end else begin
			en_d <= en_s;
			if (en_s && !en_d)
				acc_cnt <= ACC_CYC[15:0];
			else if (acc_cnt != 16'h0000)
				acc_cnt <= acc_cnt - 16'h0001;
		end
	end
	// The edge cycle itself must stay closed, hence en_d as well
	assign acc_ok = en_s && en_d && (acc_cnt == 16'h0000);

	// Registers
	// Writes during the access delay are dropped, not queued
	logic [7:0] tgt_lo, tgt_hi, ctrl;
	logic pg_bad;
	always_ff @(posedge clk_sys_i) begin
		if (rst_all) begin
			tgt_lo <= `BBMC_RST_TARGET_LOW;
			tgt_hi <= `BBMC_RST_TARGET_HIGH;
			ctrl <= `BBMC_RST_CONTROL;
		end else if (reg_wr_i && acc_ok) begin
			case (reg_addr_i)
				`BBMC_ADDR_TARGET_LOW: tgt_lo <= reg_wdata_i;
				`BBMC_ADDR_TARGET_HIGH: tgt_hi <= reg_wdata_i;
				`BBMC_ADDR_CONTROL: ctrl <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// Read port; refused accesses get no ack
	always_ff @(posedge clk_sys_i) begin
		if (rst_all) begin
			reg_rdata_o <= 8'h00;
			reg_ack_o <= 1'b0;
		end else begin
			reg_ack_o <= (reg_wr_i || reg_rd_i) && acc_ok;
			if (reg_rd_i && acc_ok) begin
				case (reg_addr_i)
					`BBMC_ADDR_TARGET_LOW: reg_rdata_o <= tgt_lo;
					`BBMC_ADDR_TARGET_HIGH: reg_rdata_o <= tgt_hi;
					`BBMC_ADDR_CONTROL: reg_rdata_o <= ctrl;
					`BBMC_ADDR_STATUS: reg_rdata_o <= {7'h00, pg_bad};
					default: reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Target code and voltage
	logic [6:0] code;
	assign code = sel_s ? tgt_hi[`BBMC_CODE_MSB:0]
		: tgt_lo[`BBMC_CODE_MSB:0];
	logic [15:0] next_target;
	assign next_target = 16'(`BBMC_BASE_MV) + 16'(code) * 16'(`BBMC_STEP_MV);

	// Slew: rate in mV per microsecond, expressed as cycles per 1 mV step
	// Step 1 mV every N cycles: 1V/ms=200, 2.5=80, 5=40, 10=20
	function automatic logic [7:0] slew_cyc(input logic [1:0] f);
		case (f)
			2'd0: slew_cyc = 8'd200;
			2'd1: slew_cyc = 8'd80;
			2'd2: slew_cyc = 8'd40;
			default: slew_cyc = 8'd20;
		endcase
	endfunction
	logic [7:0] slew_cnt;
	logic ramping;
	logic downhill_free;
	// Auto mode without ramp-PWM cannot sink: downward ramp just tracks
	assign downhill_free = !ctrl[`BBMC_CTL_RAMP] && !ctrl[`BBMC_CTL_FORCED_PWM_BIT];
	always_ff @(posedge clk_sys_i) begin
		if (rst_all || !run) begin
			reference_mv_o <= 16'h0000;
			target_mv_o <= 16'h0000;
			slew_cnt <= 8'h00;
		end else begin
			target_mv_o <= next_target;
			if (reference_mv_o == 16'h0000)
				reference_mv_o <= next_target;
			else if (reference_mv_o > next_target && downhill_free)
				reference_mv_o <= next_target;
			else if (reference_mv_o != next_target) begin
				if (slew_cnt >= slew_cyc(ctrl[`BBMC_CTL_SLEW_LO +: 2]) - 8'd1) begin
					slew_cnt <= 8'h00;
					reference_mv_o <= (reference_mv_o < next_target) ?
						reference_mv_o + 16'h0001 : reference_mv_o - 16'h0001;
				end else
					slew_cnt <= slew_cnt + 8'h01;
			end
		end
	end
	assign ramping = reference_mv_o != target_mv_o;

	// Power-not-good flag: set while out of range, cleared by status read
	// Set wins when an out-of-range sample meets a status read
	always_ff @(posedge clk_sys_i) begin
		if (rst_all || !run)
			pg_bad <= 1'b1;
		else if (!sn.vout_in_range)
			pg_bad <= 1'b1;
		else if (reg_rd_i && acc_ok && reg_addr_i == `BBMC_ADDR_STATUS)
			pg_bad <= 1'b0;
	end
	always_ff @(posedge clk_sys_i) begin
		power_not_good_flag_o <= rst_all ? 1'b1 : pg_bad;
	end

	// Mode select
	// Forced PWM wins over every light-load option
	logic pwm;
	assign pwm = ctrl[`BBMC_CTL_FORCED_PWM_BIT]
		|| (ctrl[`BBMC_CTL_RAMP] && ramping)
		|| sn.continuous;
	always_ff @(posedge clk_sys_i) begin
		pwm_mode_o <= rst_all ? 1'b0 : pwm;
	end

	// Switching sequencer
	// Ultrasonic forces a pulse once the idle count passes the 30 kHz period
	bbmc_pkg::bbmc_state_e st;
	logic [15:0] tcnt;
	logic [15:0] idle_cnt;
	logic half;
	bbmc_pkg::bbmc_switch_s next_sw;
	logic fire;
	assign fire = sn.output_below_ref
		|| (ctrl[`BBMC_CTL_USONIC] && idle_cnt >= 16'(US_CYC));
	always_ff @(posedge clk_sys_i) begin
		if (rst_all || !run) begin
			st <= bbmc_pkg::BBMC_OFF;
			tcnt <= 16'h0000;
			idle_cnt <= 16'h0000;
			half <= 1'b0;
		end else begin
			idle_cnt <= (st == bbmc_pkg::BBMC_ON) ? 16'h0000 : idle_cnt + 16'h0001;
			case (st)
				bbmc_pkg::BBMC_OFF: st <= bbmc_pkg::BBMC_IDLE;
				bbmc_pkg::BBMC_IDLE, bbmc_pkg::BBMC_SLEEP: begin
					if (!pwm && sn.no_load && !fire)
						st <= bbmc_pkg::BBMC_SLEEP;
					else if (fire || pwm) begin
						// Close input/output in PWM: every other start attempt held off, so the pulse starts one edge later
						half <= ~half;
						if (!(phase_i == bbmc_pkg::BBMC_BUCKBOOST && pwm && half)) begin
							st <= bbmc_pkg::BBMC_ON;
							tcnt <= on_time_cyc_i;
						end
					end else
						st <= bbmc_pkg::BBMC_IDLE;
				end
				bbmc_pkg::BBMC_ON: begin
					tcnt <= tcnt - 16'h0001;
					if ((phase_i == bbmc_pkg::BBMC_BUCKBOOST && !pwm)
							? sn.peak_current || tcnt == 16'h0000
							: tcnt == 16'h0000) begin
						st <= bbmc_pkg::BBMC_FREE;
						tcnt <= off_time_cyc_i;
					end
				end
				bbmc_pkg::BBMC_FREE: begin
					tcnt <= tcnt - 16'h0001;
					if (!pwm && sn.zero_current)
						st <= bbmc_pkg::BBMC_IDLE;
					else if (tcnt == 16'h0000)
						st <= (phase_i == bbmc_pkg::BBMC_BUCKBOOST) ?
							bbmc_pkg::BBMC_OFFT : bbmc_pkg::BBMC_IDLE;
				end
				bbmc_pkg::BBMC_OFFT: begin
					if (sn.zero_current || pwm)
						st <= bbmc_pkg::BBMC_IDLE;
				end
				default: st <= bbmc_pkg::BBMC_OFF;
			endcase
		end
	end

	// Switch pattern per phase and state; legs never shoot through
	always_comb begin
		next_sw = '0;
		case (st)
			bbmc_pkg::BBMC_ON: begin
				case (phase_i)
					bbmc_pkg::BBMC_BUCK: next_sw = 4'b1001;
					bbmc_pkg::BBMC_BOOST: next_sw = 4'b1010;
					default: next_sw = 4'b1010;
				endcase
			end
			bbmc_pkg::BBMC_FREE: begin
				case (phase_i)
					bbmc_pkg::BBMC_BUCK: next_sw = 4'b0101;
					default: next_sw = 4'b1001;
				endcase
			end
			bbmc_pkg::BBMC_OFFT: next_sw = 4'b0101;
			default: next_sw = 4'b0000;
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (rst_all || !run)
			switch_o <= '0;
		else
			switch_o <= next_sw;
	end
	// Sleep is dropped as soon as PWM is asked for, so the two never overlap
	// even while the sequencer still sits in the sleep state for one edge
	always_ff @(posedge clk_sys_i) begin
		deep_sleep_state_o <= !rst_all && run && !pwm
			&& st == bbmc_pkg::BBMC_SLEEP;
	end
endmodule
`default_nettype wire

// ---- testbench/bbmc_core_monitor.sv ----
// Purpose: Port assertions for the mode control core
// Assumes: Pin synchronisers add two edges of latency
// Notes: Bound into every core instance
`timescale 1ns/1ps
`default_nettype none
module bbmc_core_monitor (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Pins and strobes
	input wire logic enable_pin_i,
	input wire logic shutdown_pin_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	// Watched outputs
	input wire logic reg_ack_o,
	input wire bbmc_pkg::bbmc_switch_s switch_o,
	input wire logic power_not_good_flag_o,
	input wire logic [15:0] target_mv_o,
	input wire logic [15:0] reference_mv_o,
	input wire logic deep_sleep_state_o,
	input wire logic pwm_mode_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// Four edges cover the synchroniser and the output register
	property p_inh; !enable_pin_i [*4] |-> switch_o == 4'h0; endproperty
	a_inh: assert property (p_inh) else $error("switching while off");
	property p_sd;
		shutdown_pin_i [*4] |-> switch_o == 4'h0 && power_not_good_flag_o;
	endproperty
	a_sd: assert property (p_sd) else $error("active in shutdown");
	// A shorted leg would be destructive, so it is checked every edge
	property p_leg;
		!(switch_o.input_high_switch && switch_o.input_low_switch) &&
		!(switch_o.output_low_switch && switch_o.output_high_switch);
	endproperty
	a_leg: assert property (p_leg) else $error("leg shorted");
	property p_ack; reg_ack_o |-> $past(reg_rd_i) || $past(reg_wr_i); endproperty
	a_ack: assert property (p_ack) else $error("ack without request");
	property p_ref; !enable_pin_i [*4] |-> !reg_ack_o; endproperty
	a_ref: assert property (p_ref) else $error("ack while off");
	// Code step is 25 mV above a 1800 mV base
	property p_tgt;
		target_mv_o != 16'h0000 |-> target_mv_o >= 16'h0708 &&
		(target_mv_o - 16'h0708) % 16'h0019 == 16'h0000;
	endproperty
	a_tgt: assert property (p_tgt) else $error("target off grid");
	property p_slew;
		$past(reference_mv_o) != 16'h0000 &&
		reference_mv_o > $past(reference_mv_o) |->
		reference_mv_o == $past(reference_mv_o) + 16'h0001;
	endproperty
	a_slew: assert property (p_slew) else $error("reference jumped");
	property p_slp; deep_sleep_state_o |-> !pwm_mode_o; endproperty
	a_slp: assert property (p_slp) else $error("sleep in pwm");
	c_ack: cover property (reg_ack_o);
	c_slp: cover property (deep_sleep_state_o);
	c_ramp: cover property (reference_mv_o > $past(reference_mv_o));
endmodule
bind bbmc_core bbmc_core_monitor u_mon (.clk_sys_i(clk_sys_i),
	.nrst_i(nrst_i), .enable_pin_i(enable_pin_i),
	.shutdown_pin_i(shutdown_pin_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_ack_o(reg_ack_o), .switch_o(switch_o),
	.power_not_good_flag_o(power_not_good_flag_o),
	.target_mv_o(target_mv_o), .reference_mv_o(reference_mv_o),
	.deep_sleep_state_o(deep_sleep_state_o), .pwm_mode_o(pwm_mode_o));
`default_nettype wire

// ---- testbench/bbmc_host_model.sv ----
// Purpose: Host side of the register port
// Assumes: One-cycle strobes, ack registered one edge later
// Notes: Released address and data lines show the inverse, never a stale value
`timescale 1ns/1ps
`default_nettype none
module bbmc_host_model (
	// Clock
	input wire logic clk_sys_i,
	// Register port
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_ack_i
);
	// Idle at time zero
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// Strobe for one edge, then take ack and data together
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] v, output logic [7:0] d, output logic k);
		@(posedge clk_sys_i);
		#1 reg_wr_o = w;
		reg_rd_o = !w;
		reg_addr_o = a;
		reg_wdata_o = v;
		@(posedge clk_sys_i);
		#1 reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		k = reg_ack_i;
		d = reg_rdata_i;
		reg_addr_o = ~a;
		reg_wdata_o = ~v;
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_buck_boost_mode_control.sv ----
// Purpose: Self-checking bench for the mode control core
// Assumes: Inputs change 1 ns after the rising edge
// Notes: The fixed access delay makes the two enable waits dominate
`timescale 1ns/1ps
`default_nettype none
module test_buck_boost_mode_control;
	logic clk_sys_i, nrst_i, en, sd, sel, wr, rd, ack, k, pnf, deep_sleep_state, pwm;
	logic uv;
	bbmc_pkg::bbmc_phase_e ph;
	logic [7:0] addr, wdata, rdata, d;
	logic [15:0] tmv, rmv;
	bbmc_pkg::bbmc_switch_s sw;
	bbmc_pkg::bbmc_sense_s sense;
	int error_cnt = 0;
	int cmp_count = 0;
	bbmc_core u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.enable_pin_i(en), .shutdown_pin_i(sd), .uvlo_ok_i(uv),
		.target_select_pin_i(sel), .sense_i(sense),
		.phase_i(ph), .on_time_cyc_i(16'h0008),
		.off_time_cyc_i(16'h0008), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_ack_o(ack), .switch_o(sw), .power_not_good_flag_o(pnf),
		.target_mv_o(tmv), .reference_mv_o(rmv),
		.deep_sleep_state_o(deep_sleep_state), .pwm_mode_o(pwm));
	bbmc_host_model u_host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr),
		.reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
		.reg_rdata_i(rdata), .reg_ack_i(ack));
	task chk(input logic c, input string m);
		cmp_count++;
		if (c !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// Land 1 ns past the edge so outputs have settled
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task t_idle;
		chk(sw === 4'h0 && pnf === 1'b1, "idle");
		u_host.xfer(1'b1, 8'h04, 8'h11, d, k);
		chk(k === 1'b0, "ack while off");
	endtask
	task t_enable;
		en = 1'b1;
		cyc(50);
		u_host.xfer(1'b0, 8'h04, 8'h00, d, k);
		chk(k === 1'b0, "early access");
		cyc(20000);
		u_host.xfer(1'b0, 8'h04, 8'h00, d, k);
		chk(k === 1'b1 && d === 8'h3C, "low target");
		u_host.xfer(1'b0, 8'h01, 8'h00, d, k);
		chk(d === 8'h00, "control default");
		u_host.xfer(1'b0, 8'h07, 8'h00, d, k);
		chk(d === 8'h00, "unmapped");
		chk(tmv === 16'h0CE4, "3300 mV");
		u_host.xfer(1'b0, 8'h02, 8'h00, d, k);
		chk(d === 8'h01, "not good in soft-start");
	endtask
	task t_scale;
		u_host.xfer(1'b1, 8'h01, 8'h07, d, k);
		chk(k === 1'b1, "write taken");
		u_host.xfer(1'b1, 8'h05, 8'h50, d, k);
		sel = 1'b1;
		cyc(2003);
		chk(tmv === 16'h0ED8, "high target");
		chk(rmv >= 16'h0D43 && rmv <= 16'h0D49, "slew");
		chk(pwm === 1'b1, "pwm in ramp");
	endtask
	task t_status;
		sense.vout_in_range = 1'b1;
		cyc(5);
		u_host.xfer(1'b0, 8'h02, 8'h00, d, k);
		chk(k === 1'b1 && d === 8'h01, "held until read");
		u_host.xfer(1'b0, 8'h02, 8'h00, d, k);
		chk(d === 8'h00 && pnf === 1'b0, "flag clear");
	endtask
	task t_modes;
		sense.no_load = 1'b1;
		for (int i = 0; i < 9000 && rmv !== tmv; i++) cyc(1);
		u_host.xfer(1'b1, 8'h01, 8'h08, d, k);
		cyc(20);
		chk(pwm === 1'b1 && deep_sleep_state === 1'b0, "forced pwm");
		u_host.xfer(1'b1, 8'h01, 8'h00, d, k);
		cyc(24);
		chk(deep_sleep_state === 1'b1 && pwm === 1'b0, "deep sleep");
		u_host.xfer(1'b1, 8'h01, 8'h10, d, k);
		for (int i = 0; i < 7000 && sw === 4'h0; i++) cyc(1);
		chk(sw === 4'h9, "ultrasonic pulse");
	endtask
	task t_phase;
		u_host.xfer(1'b1, 8'h01, 8'h08, d, k);
		ph = bbmc_pkg::BBMC_BOOST;
		for (int i = 0; i < 100 && sw !== 4'hA; i++) cyc(1);
		chk(sw === 4'hA, "boost on");
		for (int i = 0; i < 20 && sw !== 4'h9; i++) cyc(1);
		chk(sw === 4'h9, "boost free");
		ph = bbmc_pkg::BBMC_BUCK;
		uv = 1'b0;
		cyc(5);
		chk(sw === 4'h0 && pnf === 1'b1, "no supply");
		uv = 1'b1;
		cyc(5);
	endtask
	task t_shutdown;
		sd = 1'b1;
		cyc(5);
		chk(sw === 4'h0 && pnf === 1'b1 && tmv === 16'h0000, "off");
		sd = 1'b0;
		cyc(20050);
		u_host.xfer(1'b0, 8'h05, 8'h00, d, k);
		chk(k === 1'b1 && d === 8'h3C, "defaults back");
	endtask
	task final_report;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		nrst_i = 1'b0;
		en = 1'b0;
		sd = 1'b0;
		sel = 1'b0;
		uv = 1'b1;
		ph = bbmc_pkg::BBMC_BUCK;
		sense = '0;
		cyc(10);
		nrst_i = 1'b1;
		cyc(2);
		t_idle;
		t_enable;
		t_scale;
		t_status;
		t_modes;
		t_phase;
		t_shutdown;
		final_report;
	end
	// Watchdog: about 80000 cycles against some 60000 expected
	initial begin
		#400000;
		error_cnt++;
		final_report;
	end
endmodule
`default_nettype wire
